/* rtl/pot_lock_command_sequencer.sv */
`timescale 1ns/1ps
`include "pot_lock_defines.svh"

module pot_lock_command_sequencer
    import pot_lock_pkg::*;
(
    // Clock and control
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       enable,
    // Command port
    input  wire logic       cmd_valid,
    input  wire logic [1:0] cmd,
    output logic            cmd_ready,
    output logic            cmd_done,
    // Host view of the device
    output logic [5:0]      wiper_est,
    output logic            lock_est,
    // Device pins
    output logic            select_n,
    output logic            select_hv,
    output logic            up_down
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        state_e            st;
        logic [1:0]        op;
        logic [`CNT_W-1:0] cnt;
        logic              ready;
        logic              done;
        logic [5:0]        wiper;
        logic              lock;
        logic              sel_n;
        logic              hv;
        logic              ud;
    } regs_s;

    regs_s r;
    regs_s next_r;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    // Phase lengths come from the setup and hold counts in the defines
    // header; the store path adds the whole write cycle, and cmd_ready
    // stays low all that time so that no request reaches a deaf device
    // Decode flags for the sequencer
    logic take_cmd;
    logic cmd_is_store;
    logic op_is_store;
    logic op_is_inc;
    logic op_is_dec;
    logic at_top;
    logic at_bottom;
    logic cnt_done;

    // Request qualifiers seen in idle
    assign take_cmd     = cmd_valid && r.ready;
    assign cmd_is_store = (cmd == CMD_LOCK) || (cmd == CMD_UNLOCK);

    // Held operation of the running sequence
    assign op_is_store  = (r.op == CMD_LOCK) || (r.op == CMD_UNLOCK);
    assign op_is_inc    = (r.op == CMD_INC);
    assign op_is_dec    = (r.op == CMD_DEC);

    // Saturation limits of the tracked wiper
    assign at_top       = (r.wiper == `WIPER_MAX);
    assign at_bottom    = (r.wiper == `WIPER_MIN);

    // Phase timer expiry
    assign cnt_done     = (r.cnt == `CNT_ZERO);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Next-state logic for all pin sequences
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        // Phase timer counts down to zero and rests there
        if (!cnt_done) begin
            next_r.cnt = r.cnt - `CNT_ONE;
        end
        case (r.st)
            // Wait for a request with select parked at normal high
            ST_IDLE: begin
                next_r.ready = 1'b1;
                if (take_cmd) begin
                    next_r.ready = 1'b0;
                    next_r.op    = cmd;
                    next_r.sel_n = 1'b1;
                    // Store and increment preset up/down high, decrement presets it low
                    next_r.ud    = cmd_is_store || (cmd == CMD_INC);
                    next_r.cnt   = `CNT_W'(`SETUP_CYC);
                    next_r.st    = ST_SETUP;
                end
            end
            // Up/down settles before select moves
            ST_SETUP: begin
                if (cnt_done) begin
                    next_r.cnt = `CNT_W'(`HOLD_CYC);
                    if (op_is_store) begin
                        // Select climbs from normal high to the high-voltage level
                        next_r.hv = 1'b1;
                        next_r.st = ST_HV;
                    end else begin
                        // Select falls: the device latches the step direction here
                        next_r.sel_n = 1'b0;
                        next_r.st    = ST_STEP;
                    end
                end
            end
            // High voltage stands on select
            ST_HV: begin
                if (cnt_done) begin
                    // Lock: up/down low; unlock: keep it static
                    next_r.ud  = (r.op == CMD_UNLOCK);
                    next_r.cnt = `CNT_W'(`SETUP_CYC);
                    next_r.st  = ST_UD_SET;
                end
            end
            // Up/down has its final level, drop select back to normal high
            ST_UD_SET: begin
                if (cnt_done) begin
                    next_r.hv   = 1'b0;
                    next_r.lock = (r.op == CMD_LOCK);
                    next_r.cnt  = `CNT_W'(`NV_WRITE_CYC);
                    next_r.st   = ST_BUSY;
                end
            end
            // Select low: one rising edge of up/down moves the wiper
            ST_STEP: begin
                if (cnt_done) begin
                    next_r.cnt = `CNT_W'(`HOLD_CYC);
                    if (op_is_inc && r.ud) begin
                        // Increment starts high, so it first needs a low phase
                        next_r.ud = 1'b0;
                    end else begin
                        // Rising edge of up/down steps the wiper
                        next_r.ud = 1'b1;
                        if (op_is_inc && !at_top) begin
                            next_r.wiper = r.wiper + 6'h01;
                        end else if (op_is_dec && !at_bottom) begin
                            next_r.wiper = r.wiper - 6'h01;
                        end
                        next_r.st = ST_RELEASE;
                    end
                end
            end
            // Park up/down so that the select rise starts no store
            ST_RELEASE: begin
                if (cnt_done) begin
                    if (op_is_dec && r.ud) begin
                        // Decrement must end low, a high level here would store
                        next_r.ud  = 1'b0;
                        next_r.cnt = `CNT_W'(`HOLD_CYC);
                    end else begin
                        next_r.sel_n = 1'b1;
                        next_r.done  = 1'b1;
                        next_r.st    = ST_IDLE;
                    end
                end
            end
            // Device ignores all commands until the write cycle ends
            ST_BUSY: begin
                // Write cycle timer counts from the return of select to normal high
                if (cnt_done) begin
                    next_r.done = 1'b1;
                    next_r.st   = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
    end

    // Register stage with clock enable
    // Enable low holds every phase timer and pin level as it stands
    always_ff @(posedge clk) begin
        if (reset) begin
            r.st    <= ST_IDLE;
            r.op    <= CMD_LOCK;
            r.cnt   <= `CNT_ZERO;
            r.ready <= 1'b0;
            r.done  <= 1'b0;
            r.wiper <= `WIPER_MIN;
            r.lock  <= 1'b0;
            r.sel_n <= 1'b1;
            r.hv    <= 1'b0;
            r.ud    <= 1'b1;
        end else if (enable) begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    // No decode gate sits between the state and a pin,
    // so the device never sees a glitch on select or up/down
    assign cmd_ready = r.ready;
    assign cmd_done  = r.done;
    assign wiper_est = r.wiper;
    assign lock_est  = r.lock;
    assign select_n  = r.sel_n;
    assign select_hv = r.hv;
    assign up_down   = r.ud;

endmodule : pot_lock_command_sequencer

/* shared/pot_lock_defines.svh */
`ifndef POT_LOCK_DEFINES_SVH
`define POT_LOCK_DEFINES_SVH

// Wiper code range
`define WIPER_MIN          6'h00
`define WIPER_MAX          6'h3f
// Timing (ns, write cycle in us) and derived cycle counts at 40 MHz
`define CLK_PERIOD_NS      25
`define SETUP_NS           500
`define HOLD_NS            500
`define SETUP_CYC          ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC           ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NV_WRITE_US        5000
`define NV_WRITE_CYC       ((`NV_WRITE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              18
`define CNT_ZERO           18'h00000
`define CNT_ONE            18'h00001

`endif

/* shared/pot_lock_pkg.sv */
package pot_lock_pkg;

    // Commands accepted on the host command port
    typedef enum logic [1:0] {
        CMD_LOCK   = 2'h0,   // Write wiper to memory and set lock
        CMD_UNLOCK = 2'h1,   // Write wiper to memory and clear lock
        CMD_INC    = 2'h2,   // Plain increment, no store
        CMD_DEC    = 2'h3    // Plain decrement, no store
    } cmd_e;

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_SETUP   = 7'h02,
        ST_HV      = 7'h04,
        ST_UD_SET  = 7'h08,
        ST_RELEASE = 7'h10,
        ST_STEP    = 7'h20,
        ST_BUSY    = 7'h40
    } state_e;

endpackage : pot_lock_pkg

/* verification/pot_device_model.sv */
`timescale 1ns/1ps
module pot_device_model (
    input wire logic  clk,
    input wire logic  reset,
    input wire logic  select_n,
    input wire logic  select_hv,
    input wire logic  up_down,
    output logic [5:0] wiper,
    output logic       locked
);
    logic pn, ph, pu, up_mode;
    logic [5:0] nv_wiper = 6'h00;
    int   busy;
    // Lock flag is nonvolatile: a reset does not clear it
    initial locked = 1'b0;
    // Device reacts to pin edges; mode latched at select fall
    always @(posedge clk) begin
        if (reset) begin
            wiper <= nv_wiper; busy <= 0; pn <= 1'b1; ph <= 1'b0; pu <= 1'b1; up_mode <= 1'b1;
        end else begin
            pn <= select_n; ph <= select_hv; pu <= up_down;
            if (busy > 0) busy <= busy - 1;
            else begin
                if (pn && !select_n) up_mode <= up_down;
                if (!select_n && up_down && !pu) begin
                    if (up_mode && wiper != 6'h3f) wiper <= wiper + 6'h01;
                    else if (!up_mode && wiper != 6'h00) wiper <= wiper - 6'h01;
                end
                if (ph && !select_hv && select_n) begin
                    locked <= !up_down;
                    nv_wiper <= wiper;
                    busy <= 200000;
                end
            end
        end
    end
endmodule : pot_device_model

/* verification/pot_lock_command_sequencer_assertions.sv */
`timescale 1ns/1ps
module pot_lock_command_sequencer_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic select_n,
    input wire logic select_hv,
    input wire logic up_down,
    input wire logic lock_est,
    input wire logic cmd_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Pin relations on the select and up/down lines
    AST_HV_SETUP: assert property ($rose(select_hv) |-> select_n && up_down && $past(up_down))
        else $error("high voltage raised without both lines high");
    AST_LOCK_SET: assert property ($fell(select_hv) && !up_down |=> lock_est)
        else $error("lock not tracked after store");
    AST_HV_PROMPT: assert property ($fell(up_down) && select_hv |-> ##[1:40] !select_hv)
        else $error("select not returned promptly");
    AST_HV_LEVEL: assert property (select_hv |-> select_n)
        else $error("high voltage with select low");
    COV_DONE: cover property (cmd_done);
    COV_HV: cover property ($rose(select_hv));
    COV_SEL: cover property ($fell(select_n));
    COV_LOCK: cover property ($rose(lock_est));
endmodule : pot_lock_command_sequencer_assertions
bind pot_lock_command_sequencer pot_lock_command_sequencer_assertions chk (.clk(clk), .reset(reset),
    .select_n(select_n), .select_hv(select_hv), .up_down(up_down), .lock_est(lock_est), .cmd_done(cmd_done));

/* verification/pot_lock_command_sequencer_test.sv */
`timescale 1ns/1ps
module pot_lock_command_sequencer_test;
    import pot_lock_pkg::*;
    logic clk = 0, reset = 1, enable = 1, cmd_valid = 0;
    cmd_e cmd = CMD_INC;
    logic cmd_ready, cmd_done, lock_est, select_n, select_hv, up_down, m_lock;
    logic [5:0] wiper_est, m_wiper;
    int num_errors = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    pot_lock_command_sequencer dut (.clk(clk), .reset(reset), .enable(enable), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .wiper_est(wiper_est), .lock_est(lock_est),
        .select_n(select_n), .select_hv(select_hv), .up_down(up_down));
    pot_device_model pot (.clk(clk), .reset(reset), .select_n(select_n), .select_hv(select_hv),
        .up_down(up_down), .wiper(m_wiper), .locked(m_lock));
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task finish_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task run_cmd(input cmd_e c);
        int n;
        @(negedge clk); cmd_valid = 1; cmd = c; n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        @(negedge clk); cmd_valid = 0; n = 0;
        while (cmd_done !== 1'b1 && n < 300) begin @(negedge clk); n++; end
        check("done", {7'h00, cmd_done}, 8'h01);
    endtask : run_cmd
    task cmp_wiper(input logic [5:0] exp);
        check("wiper_est", {2'h0, wiper_est}, {2'h0, exp});
        check("device wiper", {2'h0, m_wiper}, {2'h0, exp});
    endtask : cmp_wiper
    task do_reset();
        @(negedge clk); reset = 1; repeat (12) @(negedge clk); reset = 0; repeat (2) @(negedge clk);
    endtask : do_reset
    // Step, then saturate at both ends
    task test_steps();
        run_cmd(CMD_INC); cmp_wiper(6'h01);
        repeat (2) run_cmd(CMD_DEC);
        cmp_wiper(6'h00);
        repeat (64) run_cmd(CMD_INC);
        cmp_wiper(6'h3f);
    endtask : test_steps
    // High-voltage command through the handshake, up to just after select returns
    task hv_cmd(input cmd_e c);
        int n;
        @(negedge clk); cmd_valid = 1; cmd = c; n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        @(negedge clk); cmd_valid = 0; n = 0;
        while (select_hv !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        while (select_hv !== 1'b0 && n < 200) begin @(negedge clk); n++; end
        repeat (3) @(negedge clk);
    endtask : hv_cmd
    // Store and lock, commands ignored during write, reload and unlock after power cycle
    task test_lock();
        do_reset();
        run_cmd(CMD_INC);
        hv_cmd(CMD_LOCK);
        check("lock_est", {7'h00, lock_est}, 8'h01);
        check("device lock", {7'h00, m_lock}, 8'h01);
        cmd_valid = 1; cmd = CMD_INC; repeat (200) @(negedge clk); cmd_valid = 0;
        check("ready", {7'h00, cmd_ready}, 8'h00);
        cmp_wiper(6'h01);
        do_reset();
        check("device wiper reload", {2'h0, m_wiper}, 8'h01);
        hv_cmd(CMD_UNLOCK);
        check("lock_est", {7'h00, lock_est}, 8'h00);
        check("device lock", {7'h00, m_lock}, 8'h00);
    endtask : test_lock
    initial begin
        do_reset();
        check("select_n", {7'h00, select_n}, 8'h01);
        test_steps();
        test_lock();
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule : pot_lock_command_sequencer_test
